/* File: logic/ucsc_top.v */
`timescale 1ns/10ps
`include "ucsc_defines.vh"

module ucsc_top #(
  parameter CNT_W = 5
) (
  // clock and reset
  input  wire             clk,
  input  wire             rst_b,
  // apb slave
  input  wire             psel,
  input  wire             penable,
  input  wire             pwrite,
  input  wire [7:0]       paddr,
  input  wire [31:0]      pwdata,
  output wire             pready,
  output wire             pslverr,
  output reg  [31:0]      prdata,
  // bit clock sources
  input  wire             prescaled_tick,
  input  wire             external_timer_clock_input,
  output reg              rx_bit_tick,
  output reg              tx_bit_tick,
  // fifo levels from the datapath
  input  wire [CNT_W-1:0] rx_fifo_level,
  input  wire [CNT_W-1:0] tx_fifo_space,
  // transmitter state
  input  wire             tx_enabled,
  input  wire             tx_shifting,
  // command pulses to the datapath
  output reg              mode_ptr_reset,
  output reg              rx_reset,
  output reg              rx_flags_clear,
  output reg              tx_reset,
  output reg              tx_ready_clear,
  output reg              tx_empty_clear,
  output reg              err_flags_clear,
  output reg              delta_break_clear,
  // transmit line control
  output reg              tx_force_low,
  output reg              tx_hold,
  // mode and interrupt
  output reg              modem_mode,
  output wire             irq
);

  // ==================================================
  // state codes of the break sequencer
  localparam [3:0] B_IDLE = 4'b0001;
  localparam [3:0] B_WAIT = 4'b0010;
  localparam [3:0] B_ON   = 4'b0100;
  localparam [3:0] B_STOP = 4'b1000;

  reg  [7:0]            csel_q;
  reg  [`UCSC_IRQ_W-1:0] irq_st_q;
  reg  [`UCSC_IRQ_W-1:0] irq_en_q;
  reg  [`UCSC_IRQ_W-1:0] irq_set;
  reg  [3:0]            brk_q;
  reg  [3:0]            brk_d;
  reg                   ext_s1_q;
  reg                   ext_s2_q;
  reg                   ext_s3_q;
  reg  [3:0]            div_q;
  reg                   tx_bit_d;
  reg                   rx_bit_d;
  wire                  ext_rise;
  wire                  ext16;
  wire                  wr_acc;
  wire                  rd_setup;
  wire                  cmd_wr;
  wire [2:0]            misc;
  wire                  brk_on_cmd;
  wire                  brk_off_cmd;
  wire                  mapped;

  // ==================================================
  // source pick shared by both directions
  function pick_tick;
    input [3:0] code;
    input       pre;
    input       ext;
    input       e16;
    begin
      case (code)
        `UCSC_CS_PRE:   pick_tick = pre;
        `UCSC_CS_EXT16: pick_tick = e16;
        `UCSC_CS_EXT:   pick_tick = ext;
        default:        pick_tick = 1'b0;
      endcase
    end
  endfunction

  // address decode used for writes and errors
  function is_mapped;
    input [7:0] a;
    begin
      case (a)
        `UCSC_A_CSEL, `UCSC_A_RXCNT, `UCSC_A_TXSPC,
        `UCSC_A_CMD, `UCSC_A_MODE, `UCSC_A_IRQ_ST,
        `UCSC_A_IRQ_EN, `UCSC_A_IRQ_CLR:
          is_mapped = 1'b1;
        default:
          is_mapped = 1'b0;
      endcase
    end
  endfunction

  // ==================================================
  // apb handshake, zero wait states
  assign pready   = 1'b1;
  assign mapped   = is_mapped(paddr);
  assign pslverr  = psel & penable & ~mapped;
  assign wr_acc   = psel & penable & pwrite & mapped;
  assign rd_setup = psel & ~penable & ~pwrite;
  assign cmd_wr   = wr_acc & (paddr == `UCSC_A_CMD);
  assign misc     = pwdata[6:4];

  // read data captured in the setup cycle
  always @(posedge clk) begin
    if (!rst_b) begin
      prdata <= 32'h0000_0000;
    end else if (rd_setup) begin
      prdata <= 32'h0000_0000;
      case (paddr)
        `UCSC_A_RXCNT:  prdata[CNT_W-1:0] <= rx_fifo_level;
        `UCSC_A_TXSPC:  prdata[CNT_W-1:0] <= tx_fifo_space;
        `UCSC_A_MODE:   prdata[0] <= modem_mode;
        `UCSC_A_IRQ_ST: prdata[`UCSC_IRQ_W-1:0] <= irq_st_q;
        `UCSC_A_IRQ_EN: prdata[`UCSC_IRQ_W-1:0] <= irq_en_q;
        default:        prdata <= 32'h0000_0000;
      endcase
    end
  end

  // ==================================================
  // writable configuration
  always @(posedge clk) begin
    if (!rst_b) begin
      csel_q     <= `UCSC_CS_RST;
      modem_mode <= 1'b0;
      irq_en_q   <= {`UCSC_IRQ_W{1'b0}};
    end else if (wr_acc) begin
      case (paddr)
        `UCSC_A_CSEL:   csel_q <= pwdata[7:0];
        `UCSC_A_MODE:   modem_mode <= pwdata[0];
        `UCSC_A_IRQ_EN: irq_en_q <= pwdata[`UCSC_IRQ_W-1:0];
        default:        csel_q <= csel_q;
      endcase
    end
  end

  // ==================================================
  // external timer pin synchroniser
  always @(posedge clk) begin
    if (!rst_b) begin
      ext_s1_q <= 1'b0;
      ext_s2_q <= 1'b0;
      ext_s3_q <= 1'b0;
    end else begin
      ext_s1_q <= external_timer_clock_input;
      ext_s2_q <= ext_s1_q;
      ext_s3_q <= ext_s2_q;
    end
  end

  assign ext_rise = ext_s2_q & ~ext_s3_q;
  assign ext16    = ext_rise & (div_q == `UCSC_DIV16);

  // divide the external edges by sixteen
  always @(posedge clk) begin
    if (!rst_b) begin
      div_q <= 4'h0;
    end else if (ext_rise) begin
      div_q <= div_q + 4'h1;
    end
  end

  // ==================================================
  // bit clock selection per direction
  always @* begin
    rx_bit_d = pick_tick(csel_q[7:4], prescaled_tick,
                         ext_rise, ext16);
    tx_bit_d = pick_tick(csel_q[3:0], prescaled_tick,
                         ext_rise, ext16);
  end

  // selected ticks, silent in modem mode
  always @(posedge clk) begin
    if (!rst_b) begin
      rx_bit_tick <= 1'b0;
      tx_bit_tick <= 1'b0;
    end else begin
      rx_bit_tick <= rx_bit_d & ~modem_mode;
      tx_bit_tick <= tx_bit_d & ~modem_mode;
    end
  end

  // ==================================================
  // command decode into one-cycle pulses
  always @(posedge clk) begin
    if (!rst_b) begin
      mode_ptr_reset    <= 1'b0;
      rx_reset          <= 1'b0;
      rx_flags_clear    <= 1'b0;
      tx_reset          <= 1'b0;
      tx_ready_clear    <= 1'b0;
      tx_empty_clear    <= 1'b0;
      err_flags_clear   <= 1'b0;
      delta_break_clear <= 1'b0;
    end else begin
      // pointer back to first mode register
      mode_ptr_reset <= cmd_wr & (misc == `UCSC_MC_PTR);
      rx_reset       <= cmd_wr & (misc == `UCSC_MC_RXRST);
      rx_flags_clear <= cmd_wr & (misc == `UCSC_MC_RXRST);
      tx_reset       <= cmd_wr & (misc == `UCSC_MC_TXRST);
      tx_ready_clear <= cmd_wr & (misc == `UCSC_MC_TXRST);
      tx_empty_clear <= cmd_wr &
        (((misc == `UCSC_MC_TXRST) & ~modem_mode) |
         ((misc == `UCSC_MC_ERR) & modem_mode));
      err_flags_clear <= cmd_wr & (misc == `UCSC_MC_ERR);
      delta_break_clear <= cmd_wr & ~modem_mode &
                           (misc == `UCSC_MC_DBRK);
    end
  end

  // ==================================================
  // break commands
  // enabled, uart mode, cts unused
  assign brk_on_cmd  = cmd_wr & (misc == `UCSC_MC_BRKON) &
                       tx_enabled & ~modem_mode;
  assign brk_off_cmd = cmd_wr & (misc == `UCSC_MC_BRKOFF);

  // break sequencer next state
  always @* begin
    brk_d = brk_q;
    case (brk_q)
      B_IDLE: begin
        if (brk_on_cmd) begin
          brk_d = B_WAIT;
        end
      end
      B_WAIT: begin
        // wait for shifter, then bit edge
        if (brk_off_cmd) begin
          brk_d = B_IDLE;
        end else if (~tx_shifting & tx_bit_tick) begin
          brk_d = B_ON;
        end
      end
      B_ON: begin
        if (brk_off_cmd) begin
          brk_d = B_STOP;
        end
      end
      B_STOP: begin
        if (tx_bit_tick) begin
          brk_d = B_IDLE;
        end
      end
      default: brk_d = B_IDLE;
    endcase
    if (tx_reset) begin
      brk_d = B_IDLE;
    end
  end

  // break state and line outputs
  always @(posedge clk) begin
    if (!rst_b) begin
      brk_q        <= B_IDLE;
      tx_force_low <= 1'b0;
      tx_hold      <= 1'b0;
    end else begin
      brk_q <= brk_d;
      tx_force_low <= (brk_d == B_ON) | (brk_d == B_STOP);
      tx_hold <= (brk_d != B_IDLE);
    end
  end

  // ==================================================
  // interrupt events
  always @* begin
    irq_set = {`UCSC_IRQ_W{1'b0}};
    irq_set[`UCSC_IRQ_BON]  = (brk_q == B_WAIT) &
                              (brk_d == B_ON);
    irq_set[`UCSC_IRQ_BOFF] = (brk_q == B_STOP) &
                              (brk_d == B_IDLE);
    irq_set[`UCSC_IRQ_REJ]  = cmd_wr & ~brk_on_cmd &
                              (misc == `UCSC_MC_BRKON);
  end

  // sticky status, set wins over clear
  always @(posedge clk) begin
    if (!rst_b) begin
      irq_st_q <= {`UCSC_IRQ_W{1'b0}};
    end else if (wr_acc & (paddr == `UCSC_A_IRQ_CLR)) begin
      irq_st_q <= (irq_st_q & ~pwdata[`UCSC_IRQ_W-1:0])
                  | irq_set;
    end else begin
      irq_st_q <= irq_st_q | irq_set;
    end
  end

  assign irq = |(irq_st_q & irq_en_q);

endmodule // ucsc_top

/* File: shared/ucsc_defines.vh */
// Overview of operation
// - receiver clock from bits 7-4 code
// - transmitter clock from bits 3-0 code
// - both directions pick sources independently
// - clock select works in uart mode only
// - rx byte count in bits 4-0
// - tx free space in bits 4-0
// - misc field 6-4; 001 resets pointer
// - 010 resets receiver, flags, fifo pointer
// - 011 resets transmitter; modem keeps empty
// - 100 clears errors; modem clears underrun
// - 101 clears delta break; not modem
// - 110 starts break after shifting character
// - break needs tx enabled, ignores cts
// - 111 returns mark within two bits
`ifndef UCSC_DEFINES_VH
`define UCSC_DEFINES_VH

// ==================================================
// register byte addresses
`define UCSC_A_CSEL    8'h00
`define UCSC_A_RXCNT   8'h04
`define UCSC_A_TXSPC   8'h08
`define UCSC_A_CMD     8'h0C
`define UCSC_A_MODE    8'h10
`define UCSC_A_IRQ_ST  8'h14
`define UCSC_A_IRQ_EN  8'h18
`define UCSC_A_IRQ_CLR 8'h1C

// ==================================================
// clock source codes
`define UCSC_CS_PRE    4'hD
`define UCSC_CS_EXT16  4'hE
`define UCSC_CS_EXT    4'hF
`define UCSC_CS_RST    8'hDD

// ==================================================
// command field codes, bits 6-4
`define UCSC_MC_NONE   3'h0
`define UCSC_MC_PTR    3'h1
`define UCSC_MC_RXRST  3'h2
`define UCSC_MC_TXRST  3'h3
`define UCSC_MC_ERR    3'h4
`define UCSC_MC_DBRK   3'h5
`define UCSC_MC_BRKON  3'h6
`define UCSC_MC_BRKOFF 3'h7

// ==================================================
// interrupt bits and misc
`define UCSC_IRQ_W     3
`define UCSC_IRQ_BON   0
`define UCSC_IRQ_BOFF  1
`define UCSC_IRQ_REJ   2
`define UCSC_DIV16     4'hF

`endif

/* File: tb/ucsc_asserts.sv */
`timescale 1ns/10ps
`include "ucsc_defines.vh"
// ==========================================
// checker on the top ports
module ucsc_asserts (
  // clock and reset
  input wire logic        clk,
  input wire logic        rst_b,
  // apb
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  // transmitter state and ticks
  input wire logic        tx_enabled,
  input wire logic        tx_shifting,
  input wire logic        rx_bit_tick,
  input wire logic        tx_bit_tick,
  // command outputs
  input wire logic        mode_ptr_reset,
  input wire logic        rx_reset,
  input wire logic        rx_flags_clear,
  input wire logic        tx_reset,
  input wire logic        tx_ready_clear,
  input wire logic        tx_empty_clear,
  input wire logic        err_flags_clear,
  input wire logic        delta_break_clear,
  input wire logic        tx_force_low,
  input wire logic        tx_hold,
  input wire logic        modem_mode
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  // command write decode
  wire       cmd_wr = psel && penable && pwrite && paddr == `UCSC_A_CMD;
  wire [2:0] misc   = pwdata[6:4];
  logic       pend_q;
  logic [1:0] tick_q;
  // bit ticks seen since a stop command
  always @(posedge clk) begin
    if (!rst_b || !tx_force_low) begin
      pend_q <= 1'b0;
      tick_q <= 2'h0;
    end else begin
      if (cmd_wr && misc == `UCSC_MC_BRKOFF) pend_q <= 1'b1;
      if (pend_q && tx_bit_tick) tick_q <= tick_q + 2'h1;
    end
  end
  // break steps
  sequence brk_wait;
    tx_hold && !tx_force_low;
  endsequence
  // a stop command or transmitter reset in the same cycle cancels the wait
  sequence brk_edge;
    !tx_shifting && tx_bit_tick && !tx_reset &&
    !(cmd_wr && misc == `UCSC_MC_BRKOFF);
  endsequence
  a_ptr_pulse: assert property (cmd_wr && misc == 3'h1 |=>
    mode_ptr_reset ##1 !mode_ptr_reset) else $error("pointer reset pulse");
  a_no_cmd: assert property (cmd_wr && misc == 3'h0 |=>
    !(mode_ptr_reset || rx_reset || tx_reset)) else $error("idle code acted");
  a_rx_reset: assert property (cmd_wr && misc == 3'h2 |=>
    rx_reset && rx_flags_clear && !tx_reset) else $error("receiver reset");
  a_tx_reset: assert property (cmd_wr && misc == 3'h3 |=>
    tx_reset && tx_ready_clear && tx_empty_clear != $past(modem_mode))
    else $error("tx reset");
  a_err_clear: assert property (cmd_wr && misc == 3'h4 |=>
    err_flags_clear && tx_empty_clear == $past(modem_mode))
    else $error("error clear");
  a_dbrk_clear: assert property (cmd_wr && misc == 3'h5 |=>
    delta_break_clear != $past(modem_mode)) else $error("delta break");
  a_brk_accept: assert property (cmd_wr && misc == 3'h6 && !tx_hold
    && tx_enabled && !modem_mode |=> brk_wait) else $error("break accept");
  a_brk_refuse: assert property (cmd_wr && misc == 3'h6 && !tx_hold
    && !(tx_enabled && !modem_mode) |=> !tx_hold) else $error("break refuse");
  a_brk_start: assert property (brk_wait ##0 brk_edge |=>
    tx_force_low) else $error("break start late");
  a_force_rise: assert property ($rose(tx_force_low) |->
    $past(!tx_shifting && tx_bit_tick)) else $error("break mid character");
  a_stop_mark: assert property (tick_q != 2'h2)
    else $error("stop break slow");
  a_modem_quiet: assert property (modem_mode && $past(modem_mode) |->
    !rx_bit_tick && !tx_bit_tick) else $error("tick in modem mode");
endmodule // ucsc_asserts

bind ucsc_top ucsc_asserts u_asserts (.clk(clk), .rst_b(rst_b),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .tx_enabled(tx_enabled), .tx_shifting(tx_shifting),
  .rx_bit_tick(rx_bit_tick), .tx_bit_tick(tx_bit_tick),
  .mode_ptr_reset(mode_ptr_reset), .rx_reset(rx_reset),
  .rx_flags_clear(rx_flags_clear), .tx_ready_clear(tx_ready_clear),
  .tx_reset(tx_reset), .tx_empty_clear(tx_empty_clear),
  .err_flags_clear(err_flags_clear), .delta_break_clear(delta_break_clear),
  .tx_force_low(tx_force_low), .tx_hold(tx_hold), .modem_mode(modem_mode));

/* File: tb/ucsc_partner.sv */
`timescale 1ns/10ps
// ==========================================
// datapath and line side model
module ucsc_partner #(
  parameter PRE   = 4,
  parameter HALF  = 3,
  parameter SHIFT = 20
) (
  // clock and reset
  input  wire logic clk,
  input  wire logic rst_b,
  // character load and break hold
  input  wire logic load,
  input  wire logic tx_hold,
  // clock sources and shifter
  output logic      prescaled_tick,
  output logic      external_timer_clock_input,
  output logic      tx_shifting
);
  logic [3:0] pre_q;
  logic [3:0] ext_q;
  logic [5:0] sh_q;
  assign tx_shifting = sh_q != 6'h0;
  // tick, timer pin and shifter counters
  always @(posedge clk) begin
    if (!rst_b) begin
      pre_q <= 4'h0;
      ext_q <= 4'h0;
      sh_q <= 6'h0;
      prescaled_tick <= 1'b0;
      external_timer_clock_input <= 1'b0;
    end else begin
      pre_q <= pre_q == 4'(PRE - 1) ? 4'h0 : pre_q + 4'h1;
      prescaled_tick <= pre_q == 4'(PRE - 1);
      ext_q <= ext_q == 4'(HALF - 1) ? 4'h0 : ext_q + 4'h1;
      if (ext_q == 4'(HALF - 1))
        external_timer_clock_input <= !external_timer_clock_input;
      if (load && !tx_hold) sh_q <= 6'(SHIFT);
      else if (sh_q != 6'h0) sh_q <= sh_q - 6'h1;
    end
  end
endmodule // ucsc_partner

/* File: tb/tb_uart_clock_select_and_command.sv */
`timescale 1ns/10ps
`include "ucsc_defines.vh"
// ==========================================
// bench for clock select and commands
module tb_uart_clock_select_and_command;
  logic        clk = 0, rst_b = 0, psel = 0, penable = 0, pwrite = 0;
  logic        load = 0, tx_enabled = 0, pready, pslverr, e, re;
  logic        pre_t, ext_i, rxt, txt, shf, hold, flow, irq;
  logic [7:0]  paddr = 0, ra, rd;
  logic [4:0]  rxl = 0, txs = 0, rl;
  logic [31:0] pwdata = 0, prdata, q;
  int          bad_count = 0, checks = 0, n, r, t;
  logic [7:0]  cs [4] = '{8'hDE, 8'hFD, 8'hEF, 8'h00};
  // rows: address, fifo level, read data, error
  logic [21:0] rows [8] = '{{8'h04, 5'h1F, 8'h1F, 1'b0},
    {8'h04, 5'h0A, 8'h0A, 1'b0}, {8'h08, 5'h1F, 8'h00, 1'b0},
    {8'h08, 5'h05, 8'h1A, 1'b0}, {8'h00, 5'h03, 8'h00, 1'b0},
    {8'h0C, 5'h03, 8'h00, 1'b0}, {8'h1C, 5'h03, 8'h00, 1'b0},
    {8'h20, 5'h03, 8'h00, 1'b1}};
  ucsc_top dut (.clk(clk), .rst_b(rst_b), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .pslverr(pslverr), .prdata(prdata), .prescaled_tick(pre_t),
    .external_timer_clock_input(ext_i), .rx_bit_tick(rxt),
    .tx_bit_tick(txt), .rx_fifo_level(rxl), .tx_fifo_space(txs),
    .tx_enabled(tx_enabled), .tx_shifting(shf), .mode_ptr_reset(),
    .rx_reset(), .rx_flags_clear(), .tx_reset(), .tx_ready_clear(),
    .tx_empty_clear(), .err_flags_clear(), .delta_break_clear(),
    .tx_force_low(flow), .tx_hold(hold), .modem_mode(), .irq(irq));
  ucsc_partner u_far (.clk(clk), .rst_b(rst_b), .load(load),
    .tx_hold(hold), .prescaled_tick(pre_t),
    .external_timer_clock_input(ext_i), .tx_shifting(shf));
  // clock
  always #25 clk = ~clk;
  task complete_run;
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task near(input int g, input int x);
    chk(g > x + 1 || g + 1 < x, 0);
  endtask
  // one apb transfer, then an idle cycle
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1;
    @(posedge clk);
    while (pready !== 1) begin
      @(posedge clk);
    end
    q = prdata;
    e = pslverr;
    psel <= 0;
    penable <= 0;
    @(posedge clk);
  endtask
  task cnt;
    r = 0;
    t = 0;
    repeat (192) begin
      @(posedge clk);
      r += rxt;
      t += txt;
    end
  endtask
  function int ex(input logic [3:0] c);
    return c == `UCSC_CS_PRE ? 48 : c == `UCSC_CS_EXT16 ? 2 :
      c == `UCSC_CS_EXT ? 32 : 0;
  endfunction
  task do_reset;
    rst_b <= 0;
    repeat (2) @(posedge clk);
    rst_b <= 1;
    @(posedge clk);
  endtask
  // watchdog
  initial begin
    #300000;
    bad_count++;
    complete_run;
  end
  // main sequence
  initial begin
    do_reset;
    chk({irq, flow, hold}, 0);
    cnt;
    near(r, 48);
    near(t, 48);
    $display("reset test done");
    foreach (rows[i]) begin
      {ra, rl, rd, re} = rows[i];
      rxl <= rl;
      txs <= ~rl;
      apb(0, ra, 0);
      chk(q, {24'h0, rd});
      chk(e, re);
    end
    $display("register rows done");
    foreach (cs[i]) begin
      apb(1, `UCSC_A_CSEL, cs[i]);
      cnt;
      near(r, ex(cs[i][7:4]));
      near(t, ex(cs[i][3:0]));
    end
    apb(1, `UCSC_A_CSEL, 32'hDD);
    apb(1, `UCSC_A_MODE, 1);
    apb(0, `UCSC_A_MODE, 0);
    chk(q, 1);
    cnt;
    chk(r + t, 0);
    $display("clock select done");
    for (int m = 1; m >= 0; m--) begin
      apb(1, `UCSC_A_MODE, m);
      for (int c = 0; c < 7; c++) apb(1, `UCSC_A_CMD, c << 4);
    end
    apb(0, `UCSC_A_IRQ_ST, 0);
    chk(q, 4);
    apb(1, `UCSC_A_IRQ_EN, 7);
    chk(irq, 1);
    apb(1, `UCSC_A_IRQ_CLR, 7);
    chk(irq, 0);
    $display("command codes done");
    tx_enabled <= 1;
    load <= 1;
    @(posedge clk);
    load <= 0;
    apb(1, `UCSC_A_CMD, 32'h60);
    chk({hold, flow, shf}, 3'b101);
    n = 0;
    while (flow !== 1 && n < 100) begin
      @(posedge clk);
      n++;
    end
    chk(flow, 1);
    chk(shf, 0);
    apb(0, `UCSC_A_IRQ_ST, 0);
    chk(irq, 1);
    chk(q, 1);
    apb(1, `UCSC_A_IRQ_CLR, 1);
    apb(1, `UCSC_A_CMD, 32'h70);
    n = 0;
    while (flow !== 0 && n < 8) begin
      @(posedge clk);
      n++;
    end
    chk(n < 8, 1);
    apb(0, `UCSC_A_IRQ_ST, 0);
    chk(hold, 0);
    chk(q, 2);
    $display("break test done");
    apb(1, `UCSC_A_CSEL, 32'hEE);
    do_reset;
    apb(0, `UCSC_A_IRQ_ST, 0);
    chk(q, 0);
    cnt;
    near(r, 48);
    near(t, 48);
    $display("second reset done");
    complete_run;
  end
endmodule // tb_uart_clock_select_and_command
